//--- hw/cpurf_pkg.sv
package cpurf_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFS_DATA_REG_0         = 8'h00;
    localparam logic [7:0] OFS_DATA_REG_1         = 8'h04;
    localparam logic [7:0] OFS_DATA_REG_2         = 8'h08;
    localparam logic [7:0] OFS_DATA_REG_3         = 8'h0C;
    localparam logic [7:0] OFS_ADDR_REG_0         = 8'h10;
    localparam logic [7:0] OFS_ADDR_REG_1         = 8'h14;
    localparam logic [7:0] OFS_FRAME_BASE_PTR     = 8'h18;
    localparam logic [7:0] OFS_INSTRUCTION_PTR    = 8'h1C;
    localparam logic [7:0] OFS_VECTOR_TABLE_BASE  = 8'h20;
    localparam logic [7:0] OFS_USER_STACK_PTR     = 8'h24;
    localparam logic [7:0] OFS_IRQ_STACK_PTR      = 8'h28;
    localparam logic [7:0] OFS_STATIC_BASE_PTR    = 8'h2C;
    localparam logic [7:0] OFS_FLAG_WORD          = 8'h30;
    localparam logic [7:0] OFS_WIDE_DATA_PAIR_LOW = 8'h34;
    localparam logic [7:0] OFS_WIDE_DATA_PAIR_HI  = 8'h38;
    localparam logic [7:0] OFS_WIDE_ADDR_PAIR     = 8'h3C;

    // Flag word field positions.
    localparam int FLG_CARRY    = 0;
    localparam int FLG_DEBUG    = 1;
    localparam int FLG_ZERO     = 2;
    localparam int FLG_SIGN     = 3;
    localparam int FLG_BANK     = 4;
    localparam int FLG_OVERFLOW = 5;
    localparam int FLG_INT_EN   = 6;
    localparam int FLG_STACK    = 7;
    localparam int FLG_IPL_LO   = 12;
    localparam int FLG_IPL_HI   = 14;

    // Defined flag bits; reserved bits 8 to 11 and 15 read as zero.
    localparam logic [15:0] FLG_DEFINED_MASK = 16'h70FF;
    localparam logic [15:0] FLG_RESET        = 16'h0000;

    // Software interrupt numbers below this bound select the interrupt stack.
    localparam logic [5:0]  SWI_STACK_LIMIT  = 6'h20;

    // Memory map of the 1-megabyte linear space.
    localparam logic [19:0] PERIPH_LAST      = 20'h003FF;
    localparam logic [19:0] RAM_FIRST        = 20'h00400;
    localparam logic [19:0] RAM_LAST         = 20'h7FFFF;
    localparam logic [19:0] ROM_FIRST        = 20'h80000;
    localparam logic [19:0] VECTOR_FIRST     = 20'hFFFDC;

    // Reset values of the other registers.
    localparam logic [15:0] REG16_RESET      = 16'h0000;
    localparam logic [19:0] REG20_RESET      = 20'h00000;

    // AXI response codes.
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

//--- hw/cpurf_top.sv
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Function
// - Four 16-bit general data registers.
// - First two data registers split into bytes.
// - Pairs 2 over 0, 3 over 1 form 32 bits.
// - Two 16-bit address registers, combinable 32-bit.
// - Two banks selected by flag bit 4.
// - 20-bit instruction pointer.
// - 20-bit software-settable vector table base.
// - User and interrupt stack, flag bit 7 selects.
// - Interrupts 0 to 31 clear stack select.
// - 16-bit frame base and static base registers.
// - Carry in flag bit 0.
// - Debug bit raises single-step, cleared on acknowledge.
// - Zero flag bit 2 follows result.
// - Sign flag bit 3 follows result.
// - Overflow flag bit 5 follows result.
// - Bit 6 gates maskable interrupts, ack clears.
// - Priority level bits 12-14 gates requests.
// - Bits 8-11 and 15 reserved.
// - Decode peripheral, RAM and ROM regions.
// - Fixed vector area from top at FFFDC.
module cpurf_top
    import cpurf_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        alu_update,
    input  wire logic        alu_carry,
    input  wire logic        alu_zero,
    input  wire logic        alu_sign,
    input  wire logic        alu_overflow,
    input  wire logic        instr_done,
    input  wire logic        pc_load,
    input  wire logic [19:0] pc_value,
    input  wire logic        irq_req,
    input  wire logic [2:0]  irq_prio,
    input  wire logic        hw_irq_ack,
    input  wire logic        step_irq_ack,
    input  wire logic        sw_int_exec,
    input  wire logic [5:0]  sw_int_num,
    input  wire logic [19:0] decode_addr,
    output logic [19:0]      instruction_pointer,
    output logic [19:0]      vector_table_base,
    output logic [15:0]      active_stack_ptr,
    output logic [15:0]      processor_flag_word,
    output logic             irq_accept,
    output logic             single_step_irq,
    output logic             sel_periph,
    output logic             sel_ram,
    output logic             sel_rom,
    output logic             sel_vector
);

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    logic [15:0] data_ff     [2][4];
    logic [15:0] nxt_data    [2][4];
    logic [15:0] addr_ff     [2][2];
    logic [15:0] nxt_addr    [2][2];
    logic [15:0] fb_ff       [2];
    logic [15:0] nxt_fb      [2];
    logic [19:0] pc_ff;
    logic [19:0] nxt_pc;
    logic [19:0] vector_table_base_ff;
    logic [19:0] nxt_vector_table_base;
    logic [15:0] usp_ff;
    logic [15:0] nxt_usp;
    logic [15:0] isp_ff;
    logic [15:0] nxt_isp;
    logic [15:0] sb_ff;
    logic [15:0] nxt_sb;
    logic [15:0] flg_ff;
    logic [15:0] nxt_flg;
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic        accept_ff;
    logic        nxt_accept;
    logic        step_ff;
    logic        nxt_step;
    logic [3:0]  region_ff;
    logic [3:0]  nxt_region;

    // ****************************************************************
    // Bus slave state.
    // ****************************************************************
    logic        awready_ff;
    logic        nxt_awready;
    logic        wready_ff;
    logic        nxt_wready;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic        arready_ff;
    logic        nxt_arready;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic        bank;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] wmask;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_val;
    assign bank    = flg_ff[FLG_BANK];
    assign wr_fire = awready_ff & wready_ff;
    assign rd_fire = arready_ff;
    // Byte lanes turn into a bit mask so each byte half is written alone.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] val,
                                            input logic [15:0] msk);
        merge16 = (old & ~msk) | (val & msk);
    endfunction
    function automatic logic [19:0] merge20(input logic [19:0] old,
                                            input logic [19:0] val,
                                            input logic [19:0] msk);
        merge20 = (old & ~msk) | (val & msk);
    endfunction

    // ****************************************************************
    // Address hit decode.
    // ****************************************************************
    function automatic logic offset_known(input logic [7:0] a);
        unique case (a)
            OFS_DATA_REG_0, OFS_DATA_REG_1, OFS_DATA_REG_2, OFS_DATA_REG_3,
            OFS_ADDR_REG_0, OFS_ADDR_REG_1, OFS_FRAME_BASE_PTR,
            OFS_INSTRUCTION_PTR, OFS_VECTOR_TABLE_BASE, OFS_USER_STACK_PTR,
            OFS_IRQ_STACK_PTR, OFS_STATIC_BASE_PTR, OFS_FLAG_WORD,
            OFS_WIDE_DATA_PAIR_LOW, OFS_WIDE_DATA_PAIR_HI,
            OFS_WIDE_ADDR_PAIR: offset_known = 1'b1;
            default:            offset_known = 1'b0;
        endcase
    endfunction
    assign wr_hit = offset_known(s_axi_awaddr);
    assign rd_hit = offset_known(s_axi_araddr);

    // ****************************************************************
    // Read multiplexer over the selected bank.
    // ****************************************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFS_DATA_REG_0:         rd_val[15:0] = data_ff[bank][0];
            OFS_DATA_REG_1:         rd_val[15:0] = data_ff[bank][1];
            OFS_DATA_REG_2:         rd_val[15:0] = data_ff[bank][2];
            OFS_DATA_REG_3:         rd_val[15:0] = data_ff[bank][3];
            OFS_ADDR_REG_0:         rd_val[15:0] = addr_ff[bank][0];
            OFS_ADDR_REG_1:         rd_val[15:0] = addr_ff[bank][1];
            OFS_FRAME_BASE_PTR:     rd_val[15:0] = fb_ff[bank];
            OFS_INSTRUCTION_PTR:    rd_val[19:0] = pc_ff;
            OFS_VECTOR_TABLE_BASE:  rd_val[19:0] = vector_table_base_ff;
            OFS_USER_STACK_PTR:     rd_val[15:0] = usp_ff;
            OFS_IRQ_STACK_PTR:      rd_val[15:0] = isp_ff;
            OFS_STATIC_BASE_PTR:    rd_val[15:0] = sb_ff;
            OFS_FLAG_WORD:          rd_val[15:0] = flg_ff & FLG_DEFINED_MASK;
            OFS_WIDE_DATA_PAIR_LOW: rd_val = {data_ff[bank][2], data_ff[bank][0]};
            OFS_WIDE_DATA_PAIR_HI:  rd_val = {data_ff[bank][3], data_ff[bank][1]};
            OFS_WIDE_ADDR_PAIR:     rd_val = {addr_ff[bank][1], addr_ff[bank][0]};
            default:                rd_val = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Register file and flag word next state.
    // ****************************************************************
    always_comb begin
        nxt_data = data_ff;
        nxt_addr = addr_ff;
        nxt_fb   = fb_ff;
        nxt_pc   = pc_ff;
        nxt_vector_table_base = vector_table_base_ff;
        nxt_usp  = usp_ff;
        nxt_isp  = isp_ff;
        nxt_sb   = sb_ff;
        nxt_flg  = flg_ff;
        if (wr_fire) begin
            unique case (s_axi_awaddr)
                OFS_DATA_REG_0: nxt_data[bank][0] =
                    merge16(data_ff[bank][0], s_axi_wdata[15:0], wmask[15:0]);
                OFS_DATA_REG_1: nxt_data[bank][1] =
                    merge16(data_ff[bank][1], s_axi_wdata[15:0], wmask[15:0]);
                OFS_DATA_REG_2: nxt_data[bank][2] =
                    merge16(data_ff[bank][2], s_axi_wdata[15:0], wmask[15:0]);
                OFS_DATA_REG_3: nxt_data[bank][3] =
                    merge16(data_ff[bank][3], s_axi_wdata[15:0], wmask[15:0]);
                OFS_ADDR_REG_0: nxt_addr[bank][0] =
                    merge16(addr_ff[bank][0], s_axi_wdata[15:0], wmask[15:0]);
                OFS_ADDR_REG_1: nxt_addr[bank][1] =
                    merge16(addr_ff[bank][1], s_axi_wdata[15:0], wmask[15:0]);
                OFS_FRAME_BASE_PTR: nxt_fb[bank] =
                    merge16(fb_ff[bank], s_axi_wdata[15:0], wmask[15:0]);
                OFS_INSTRUCTION_PTR: nxt_pc =
                    merge20(pc_ff, s_axi_wdata[19:0], wmask[19:0]);
                OFS_VECTOR_TABLE_BASE: nxt_vector_table_base =
                    merge20(vector_table_base_ff, s_axi_wdata[19:0], wmask[19:0]);
                OFS_USER_STACK_PTR: nxt_usp =
                    merge16(usp_ff, s_axi_wdata[15:0], wmask[15:0]);
                OFS_IRQ_STACK_PTR: nxt_isp =
                    merge16(isp_ff, s_axi_wdata[15:0], wmask[15:0]);
                OFS_STATIC_BASE_PTR: nxt_sb =
                    merge16(sb_ff, s_axi_wdata[15:0], wmask[15:0]);
                OFS_FLAG_WORD: nxt_flg =
                    merge16(flg_ff, s_axi_wdata[15:0], wmask[15:0]) & FLG_DEFINED_MASK;
                OFS_WIDE_DATA_PAIR_LOW: begin
                    nxt_data[bank][0] =
                        merge16(data_ff[bank][0], s_axi_wdata[15:0], wmask[15:0]);
                    nxt_data[bank][2] =
                        merge16(data_ff[bank][2], s_axi_wdata[31:16], wmask[31:16]);
                end
                OFS_WIDE_DATA_PAIR_HI: begin
                    nxt_data[bank][1] =
                        merge16(data_ff[bank][1], s_axi_wdata[15:0], wmask[15:0]);
                    nxt_data[bank][3] =
                        merge16(data_ff[bank][3], s_axi_wdata[31:16], wmask[31:16]);
                end
                OFS_WIDE_ADDR_PAIR: begin
                    nxt_addr[bank][0] =
                        merge16(addr_ff[bank][0], s_axi_wdata[15:0], wmask[15:0]);
                    nxt_addr[bank][1] =
                        merge16(addr_ff[bank][1], s_axi_wdata[31:16], wmask[31:16]);
                end
                default: nxt_sb = sb_ff;
            endcase
        end
        if (pc_load) begin
            nxt_pc = pc_value;
        end
        if (alu_update) begin
            nxt_flg[FLG_CARRY]    = alu_carry;
            nxt_flg[FLG_ZERO]     = alu_zero;
            nxt_flg[FLG_SIGN]     = alu_sign;
            nxt_flg[FLG_OVERFLOW] = alu_overflow;
        end
        if (step_irq_ack) begin
            nxt_flg[FLG_DEBUG] = 1'b0;
        end
        if (hw_irq_ack | step_irq_ack) begin
            nxt_flg[FLG_INT_EN] = 1'b0;
            nxt_flg[FLG_STACK]  = 1'b0;
        end
        if (sw_int_exec && (sw_int_num < SWI_STACK_LIMIT)) begin
            nxt_flg[FLG_STACK] = 1'b0;
        end
        nxt_sp = nxt_flg[FLG_STACK] ? nxt_usp : nxt_isp;
    end

    // ****************************************************************
    // Interrupt gating and memory map decode.
    // ****************************************************************
    always_comb begin
        nxt_accept = irq_req & flg_ff[FLG_INT_EN]
                   & (irq_prio > flg_ff[FLG_IPL_HI:FLG_IPL_LO]);
        nxt_step   = instr_done & flg_ff[FLG_DEBUG];
        nxt_region[0] = (decode_addr <= PERIPH_LAST);
        nxt_region[1] = (decode_addr >= RAM_FIRST) && (decode_addr <= RAM_LAST);
        nxt_region[2] = (decode_addr >= ROM_FIRST);
        nxt_region[3] = (decode_addr >= VECTOR_FIRST);
    end

    // ****************************************************************
    // Bus handshake next state.
    // ****************************************************************
    always_comb begin
        nxt_awready = 1'b0;
        nxt_wready  = 1'b0;
        nxt_bvalid  = bvalid_ff & ~s_axi_bready;
        nxt_bresp   = bresp_ff;
        nxt_arready = 1'b0;
        nxt_rvalid  = rvalid_ff & ~s_axi_rready;
        nxt_rresp   = rresp_ff;
        nxt_rdata   = rdata_ff;
        if (s_axi_awvalid && s_axi_wvalid && !wr_fire && !bvalid_ff) begin
            nxt_awready = 1'b1;
            nxt_wready  = 1'b1;
        end
        if (wr_fire) begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_arvalid && !rd_fire && !rvalid_ff) begin
            nxt_arready = 1'b1;
        end
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
            nxt_rdata  = rd_val;
        end
    end

    // ****************************************************************
    // State registers.
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int b = 0; b < 2; b++) begin
                for (int r = 0; r < 4; r++) begin
                    data_ff[b][r] <= REG16_RESET;
                end
                addr_ff[b][0] <= REG16_RESET;
                addr_ff[b][1] <= REG16_RESET;
                fb_ff[b]      <= REG16_RESET;
            end
            pc_ff      <= REG20_RESET;
            vector_table_base_ff    <= REG20_RESET;
            usp_ff     <= REG16_RESET;
            isp_ff     <= REG16_RESET;
            sb_ff      <= REG16_RESET;
            flg_ff     <= FLG_RESET;
            sp_ff      <= REG16_RESET;
            accept_ff  <= 1'b0;
            step_ff    <= 1'b0;
            region_ff  <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            data_ff    <= nxt_data;
            addr_ff    <= nxt_addr;
            fb_ff      <= nxt_fb;
            pc_ff      <= nxt_pc;
            vector_table_base_ff    <= nxt_vector_table_base;
            usp_ff     <= nxt_usp;
            isp_ff     <= nxt_isp;
            sb_ff      <= nxt_sb;
            flg_ff     <= nxt_flg;
            sp_ff      <= nxt_sp;
            accept_ff  <= nxt_accept;
            step_ff    <= nxt_step;
            region_ff  <= nxt_region;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign s_axi_awready       = awready_ff;
    assign s_axi_wready        = wready_ff;
    assign s_axi_bvalid        = bvalid_ff;
    assign s_axi_bresp         = bresp_ff;
    assign s_axi_arready       = arready_ff;
    assign s_axi_rvalid        = rvalid_ff;
    assign s_axi_rresp         = rresp_ff;
    assign s_axi_rdata         = rdata_ff;
    assign instruction_pointer = pc_ff;
    assign vector_table_base   = vector_table_base_ff;
    assign active_stack_ptr    = sp_ff;
    assign processor_flag_word = flg_ff;
    assign irq_accept          = accept_ff;
    assign single_step_irq     = step_ff;
    assign sel_periph          = region_ff[0];
    assign sel_ram             = region_ff[1];
    assign sel_rom             = region_ff[2];
    assign sel_vector          = region_ff[3];

endmodule // cpurf_top

//--- dv/cpurf_props.sv
`timescale 1ns/1ps
// ****************************************
// Flag word and decode checker.
// ****************************************
module cpurf_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        instr_done,
    input wire logic        irq_req,
    input wire logic [2:0]  irq_prio,
    input wire logic        hw_irq_ack,
    input wire logic        step_irq_ack,
    input wire logic        sw_int_exec,
    input wire logic [5:0]  sw_int_num,
    input wire logic [19:0] decode_addr,
    input wire logic [15:0] processor_flag_word,
    input wire logic        irq_accept,
    input wire logic        single_step_irq,
    input wire logic        sel_periph,
    input wire logic        sel_ram,
    input wire logic        sel_rom,
    input wire logic        sel_vector
);
    wire [15:0] fw = processor_flag_word;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_step_req; instr_done && fw[1]; endsequence
    sequence s_swi_low; sw_int_exec && (sw_int_num < 6'h20); endsequence
    property p_rsv; (fw & 16'h8F00) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag bit set");
    property p_acc; irq_accept == $past(irq_req && fw[6] && (irq_prio > fw[14:12])); endproperty
    a_acc: assert property (p_acc) else $error("accept wrong");
    property p_step; s_step_req |=> single_step_irq; endproperty
    a_step: assert property (p_step) else $error("no single step");
    property p_sack; step_irq_ack |=> !fw[1]; endproperty
    a_sack: assert property (p_sack) else $error("debug not cleared");
    property p_hack; hw_irq_ack |=> fw[7:6] == 2'b00; endproperty
    a_hack: assert property (p_hack) else $error("ack clear missing");
    property p_swi; s_swi_low |=> !fw[7]; endproperty
    a_swi: assert property (p_swi) else $error("stack select kept");
    property p_per; decode_addr <= 20'h003FF |=> sel_periph && !sel_ram; endproperty
    a_per: assert property (p_per) else $error("periph decode");
    property p_ram; decode_addr inside {[20'h00400:20'h7FFFF]} |=> sel_ram && !sel_rom; endproperty
    a_ram: assert property (p_ram) else $error("ram decode");
    property p_vec; decode_addr >= 20'hFFFDC |=> sel_vector && sel_rom; endproperty
    a_vec: assert property (p_vec) else $error("vector decode");
endmodule // cpurf_props
bind cpurf_top cpurf_props u_props (
    .aclk, .aresetn, .instr_done, .irq_req, .irq_prio, .hw_irq_ack, .step_irq_ack,
    .sw_int_exec, .sw_int_num, .decode_addr, .processor_flag_word, .irq_accept,
    .single_step_irq, .sel_periph, .sel_ram, .sel_rom, .sel_vector
);

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ****************************************
// Register file bench.
// ****************************************
module tb_top
    import cpurf_pkg::*;
;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic alu_update = 0, alu_carry = 0, alu_zero = 0, alu_sign = 0, alu_overflow = 0;
    logic instr_done = 0, pc_load = 0, irq_req = 0, hw_irq_ack = 0, step_irq_ack = 0;
    logic sw_int_exec = 0;
    logic [2:0] irq_prio = 0;
    logic [5:0] sw_int_num = 0;
    logic [19:0] pc_value = 0, decode_addr = 0, instruction_pointer, vector_table_base;
    logic [15:0] active_stack_ptr, processor_flag_word;
    logic irq_accept, single_step_irq, sel_periph, sel_ram, sel_rom, sel_vector;
    int n_fail = 0, total_checks = 0, cyc = 0;
    logic [19:0] da [8] = '{20'h0, 20'h3FF, 20'h400, 20'h7FFFF, 20'h80000,
                            20'hFFFDB, 20'hFFFDC, 20'hFFFFF};
    logic [3:0] de [8] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h3, 4'h3};
    cpurf_top dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alu_update, .alu_carry, .alu_zero,
        .alu_sign, .alu_overflow, .instr_done, .pc_load, .pc_value, .irq_req, .irq_prio,
        .hw_irq_ack, .step_irq_ack, .sw_int_exec, .sw_int_num, .decode_addr,
        .instruction_pointer, .vector_table_base, .active_stack_ptr, .processor_flag_word,
        .irq_accept, .single_step_irq, .sel_periph, .sel_ram, .sel_rom, .sel_vector
    );
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready) aw_ok = 1'b1;
            if (s_axi_wready) w_ok = 1'b1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, r)
    endtask
    task automatic swi(input logic [5:0] n);
        sw_int_num <= n;
        sw_int_exec <= 1'b1;
        tick(1);
        sw_int_exec <= 1'b0;
        tick(1);
    endtask
    task automatic alu(input logic [3:0] v);
        {alu_carry, alu_zero, alu_sign, alu_overflow} <= v;
        alu_update <= 1'b1;
        tick(1);
        alu_update <= 1'b0;
        tick(1);
    endtask
    initial begin
        tick(12);
        aresetn <= 1'b1;
        rd(OFS_FLAG_WORD, 32'h0, RESP_OKAY);
        wr(OFS_DATA_REG_0, 32'h1234, 4'h3, RESP_OKAY);
        wr(OFS_DATA_REG_0, 32'hAB00, 4'h2, RESP_OKAY);
        rd(OFS_DATA_REG_0, 32'hAB34, RESP_OKAY);
        wr(OFS_DATA_REG_2, 32'h5678, 4'hF, RESP_OKAY);
        rd(OFS_WIDE_DATA_PAIR_LOW, 32'h5678AB34, RESP_OKAY);
        wr(OFS_WIDE_ADDR_PAIR, 32'hCAFE1357, 4'hF, RESP_OKAY);
        rd(OFS_ADDR_REG_1, 32'hCAFE, RESP_OKAY);
        wr(OFS_FLAG_WORD, 32'h10, 4'h3, RESP_OKAY);
        rd(OFS_DATA_REG_0, 32'h0, RESP_OKAY);
        wr(OFS_DATA_REG_0, 32'h9999, 4'h3, RESP_OKAY);
        wr(OFS_FLAG_WORD, 32'h0, 4'h3, RESP_OKAY);
        rd(OFS_DATA_REG_0, 32'hAB34, RESP_OKAY);
        wr(OFS_VECTOR_TABLE_BASE, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFS_VECTOR_TABLE_BASE, 32'hFFFFF, RESP_OKAY);
        `CHK(vector_table_base, 20'hFFFFF)
        pc_value <= 20'hABCDE;
        pc_load <= 1'b1;
        tick(1);
        pc_load <= 1'b0;
        rd(OFS_INSTRUCTION_PTR, 32'hABCDE, RESP_OKAY);
        `CHK(instruction_pointer, 20'hABCDE)
        wr(OFS_STATIC_BASE_PTR, 32'h4321, 4'h3, RESP_OKAY);
        rd(OFS_STATIC_BASE_PTR, 32'h4321, RESP_OKAY);
        wr(OFS_USER_STACK_PTR, 32'h1111, 4'h3, RESP_OKAY);
        wr(OFS_IRQ_STACK_PTR, 32'h2222, 4'h3, RESP_OKAY);
        `CHK(active_stack_ptr, 16'h2222)
        wr(OFS_FLAG_WORD, 32'h80, 4'h3, RESP_OKAY);
        `CHK(active_stack_ptr, 16'h1111)
        wr(8'h40, 32'h5, 4'hF, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_FLAG_WORD, 32'hFFFF, 4'h3, RESP_OKAY);
        irq_req <= 1'b1;
        irq_prio <= 3'h7;
        rd(OFS_FLAG_WORD, 32'h70FF, RESP_OKAY);
        `CHK(irq_accept, 1'b0)
        wr(OFS_FLAG_WORD, 32'h60C0, 4'h3, RESP_OKAY);
        tick(2);
        `CHK(irq_accept, 1'b1)
        irq_prio <= 3'h6;
        tick(2);
        `CHK(irq_accept, 1'b0)
        swi(6'h20);
        `CHK(processor_flag_word, 16'h60C0)
        swi(6'h1F);
        `CHK(processor_flag_word, 16'h6040)
        irq_prio <= 3'h7;
        hw_irq_ack <= 1'b1;
        tick(1);
        hw_irq_ack <= 1'b0;
        tick(2);
        `CHK(processor_flag_word, 16'h6000)
        `CHK(irq_accept, 1'b0)
        wr(OFS_FLAG_WORD, 32'h2, 4'h3, RESP_OKAY);
        instr_done <= 1'b1;
        tick(1);
        instr_done <= 1'b0;
        tick(1);
        `CHK(single_step_irq, 1'b1)
        step_irq_ack <= 1'b1;
        tick(1);
        step_irq_ack <= 1'b0;
        tick(1);
        `CHK(processor_flag_word, 16'h0000)
        alu(4'b1011);
        `CHK(processor_flag_word, 16'h0029)
        alu(4'b0100);
        `CHK(processor_flag_word, 16'h0004)
        for (int i = 0; i < 8; i++) begin
            decode_addr <= da[i];
            tick(2);
            `CHK({sel_periph, sel_ram, sel_rom, sel_vector}, de[i])
        end
        stop_test();
    end
endmodule // tb_top
